/* rtl/tbu_top.sv */
// Program flow trace buffer: records two-word packets of each
// non-sequential program counter change into a ring in shared SRAM.
// Assumes the execution trace interface and SRAM run on aclk.
//
// Function
// - Record processor flow changes as SRAM packets.
// - Packet is two 32-bit words per change.
// - Branches and exception entry produce packets.
// - Processor keeps access to the same SRAM.
// - Trace write wins SRAM contention.
// - Trace only while enable bit reads one.
// - Software writes to enable start or stop.
// - Stop-at-threshold clears enable at fill threshold.
// - Without threshold, pointer wraps and overwrites oldest.
// - Buffer placement and size set by software.
// - Registers decoded at base 0x41006000.
// - Four registers: position, control, flow, SRAM-location.
// - Position holds write pointer and wrap bit.
// - Flow holds threshold, stop and halt bits.
// - SRAM-location register reports trace SRAM base.
`timescale 1ns/1ps
`include "tbu_defs.svh"
module tbu_top (
	input  wire logic                   aclk,
	input  wire logic                   aresetn,
	input  wire logic [31:0]            awaddr,
	input  wire logic                   awvalid,
	output logic                        awready,
	input  wire logic [31:0]            wdata,
	input  wire logic [3:0]             wstrb,
	input  wire logic                   wvalid,
	output logic                        wready,
	output logic [1:0]                  bresp,
	output logic                        bvalid,
	input  wire logic                   bready,
	input  wire logic [31:0]            araddr,
	input  wire logic                   arvalid,
	output logic                        arready,
	output logic [31:0]                 rdata,
	output logic [1:0]                  rresp,
	output logic                        rvalid,
	input  wire logic                   rready,
	input  wire tbu_pkg::tbu_exec_t     exec_trace,
	input  wire tbu_pkg::tbu_sram_cmd_t cpu_req,
	output logic                        cpu_ack,
	output logic                        cpu_rvalid,
	output logic [31:0]                 cpu_rdata,
	output tbu_pkg::tbu_sram_cmd_t      sram_cmd,
	input  wire logic [31:0]            sram_rdata,
	output logic                        halt_req
);
	import tbu_pkg::*;

	localparam int AW = `TBU_SRAM_AW; // SRAM byte address width.

	// Whole state of the packet writer and its registers.
	typedef struct packed {
		tbu_phase_t    phase;
		logic [31:0]   master;
		logic [31:0]   flow;
		logic [AW-1:0] ptr;
		logic          wrap;
		logic          first;
		logic [31:0]   w1;
		tbu_sram_cmd_t tw;
		logic          halt;
	} tbu_top_state_t;

	tbu_top_state_t s_reg;     // Registered state.
	tbu_top_state_t s_next;    // Next state.
	tbu_regs_t      regs;      // Readback image for the bus.
	tbu_regwr_t     regwr;     // One-cycle register write strobe.
	logic           trace_en;  // Main trace enable.
	logic           ev;        // Non-sequential change this cycle.
	logic [AW-1:0]  bmask;     // Offset bits that move inside the ring.
	logic [AW-1:0]  ptr_inc;   // Pointer plus one packet.
	logic [AW-1:0]  ptr_nxt;   // Pointer after the ring fold.
	logic           wrap_hit;  // This packet fills the ring end.
	logic           wm_hit;    // This packet reaches the threshold.
	logic [31:0]    pos_wr;    // Position after a software write.
	logic           mst_wr;    // Software writes the enable byte.

	// ==========================================================
	// Helper functions
	// ==========================================================
	// Merge a written word into an old one by byte strobes.
	function automatic logic [31:0] tbu_merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] strb);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++)
		begin
			if (strb[i])
			begin
				r[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// Ring size is two to the power of field plus four bytes; a field
	// that exceeds the SRAM makes the whole SRAM the ring.
	function automatic logic [AW-1:0] tbu_buf_mask(input logic [4:0] m);
		logic [5:0] sh;
		sh = {1'b0, m} + `TBU_MASK_MIN;
		if (sh >= 6'(AW))
		begin
			return '1;
		end
		return (15'(1) << sh) - 15'(1);
	endfunction

	// ==========================================================
	// Bus slave and SRAM arbiter
	// ==========================================================
	tbu_axil_slave tbu_axil_slave_inst (
		.aclk    (aclk),
		.aresetn (aresetn),
		.awaddr  (awaddr),
		.awvalid (awvalid),
		.awready (awready),
		.wdata   (wdata),
		.wstrb   (wstrb),
		.wvalid  (wvalid),
		.wready  (wready),
		.bresp   (bresp),
		.bvalid  (bvalid),
		.bready  (bready),
		.araddr  (araddr),
		.arvalid (arvalid),
		.arready (arready),
		.rdata   (rdata),
		.rresp   (rresp),
		.rvalid  (rvalid),
		.rready  (rready),
		.regs    (regs),
		.regwr   (regwr)
	);

	tbu_sram_arb tbu_sram_arb_inst (
		.aclk       (aclk),
		.aresetn    (aresetn),
		.trace_cmd  (s_reg.tw),
		.cpu_req    (cpu_req),
		.cpu_ack    (cpu_ack),
		.cpu_rvalid (cpu_rvalid),
		.cpu_rdata  (cpu_rdata),
		.sram_cmd   (sram_cmd),
		.sram_rdata (sram_rdata)
	);

	// ==========================================================
	// Register image
	// ==========================================================
	// Pointer and wrap share the position word; the low two bits are
	// always zero because packets are word pairs.
	always_comb
	begin
		regs.position = '0;
		regs.position[AW-1:3] = s_reg.ptr[AW-1:3];
		regs.position[`TBU_POS_WRAP_BIT] = s_reg.wrap;
		regs.master = s_reg.master;
		regs.flow = s_reg.flow;
		regs.sram_base = `TBU_SRAM_BASE;
	end

	// ==========================================================
	// Ring arithmetic and event detection
	// ==========================================================
	assign trace_en = s_reg.master[`TBU_MASTER_EN_BIT];
	// Only flow changes are packets; straight-line steps never are.
	assign ev = exec_trace.valid && trace_en &&
		(exec_trace.branch || exec_trace.exception);
	assign bmask = tbu_buf_mask(s_reg.master[4:0]);
	assign ptr_inc = s_reg.ptr + `TBU_PKT_BYTES;
	assign ptr_nxt = (s_reg.ptr & ~bmask) | (ptr_inc & bmask);
	assign wrap_hit = (ptr_inc & bmask) == '0;
	assign wm_hit = ptr_nxt[AW-1:3] == s_reg.flow[AW-1:3];
	assign pos_wr = tbu_merge(regs.position, regwr.data, regwr.strb);
	assign mst_wr = regwr.valid && regwr.idx == `TBU_REG_MASTER &&
		regwr.strb[3];

	// ==========================================================
	// Packet writer and register updates
	// ==========================================================
	// A packet takes two cycles on the SRAM; a change reported while
	// the first word goes out is not recorded. The processor cannot
	// retire two flow changes in adjacent cycles, so nothing is lost.
	always_comb
	begin
		s_next = s_reg;
		s_next.tw = '0;
		s_next.halt = 1'b0;
		if (regwr.valid)
		begin
			case (regwr.idx)
				`TBU_REG_POSITION:
				begin
					s_next.ptr = {pos_wr[AW-1:3], 3'h0};
					s_next.wrap = pos_wr[`TBU_POS_WRAP_BIT];
				end
				`TBU_REG_MASTER:
				begin
					s_next.master = tbu_merge(s_reg.master, regwr.data,
						regwr.strb) & `TBU_MASTER_RW;
					if (!trace_en && s_next.master[`TBU_MASTER_EN_BIT])
					begin
						s_next.first = 1'b1;
					end
				end
				`TBU_REG_FLOW:
				begin
					s_next.flow = tbu_merge(s_reg.flow, regwr.data,
						regwr.strb) & `TBU_FLOW_RW;
				end
				default:
				begin
					s_next.first = s_next.first;
				end
			endcase
		end
		case (s_reg.phase)
			TBU_IDLE:
			begin
				if (ev)
				begin
					// Word 0: source address, bit 0 flags exception entry.
					s_next.tw.en = 1'b1;
					s_next.tw.we = 1'b1;
					s_next.tw.be = 4'hF;
					s_next.tw.addr = s_reg.ptr[AW-1:2];
					s_next.tw.data = {exec_trace.src_pc[31:1],
						exec_trace.exception};
					s_next.w1 = {exec_trace.dst_pc[31:1], s_reg.first};
					s_next.first = 1'b0;
					s_next.phase = TBU_WORD1;
				end
			end
			TBU_WORD1:
			begin
				// Word 1: destination, bit 0 marks first after enable.
				s_next.tw.en = 1'b1;
				s_next.tw.we = 1'b1;
				s_next.tw.be = 4'hF;
				s_next.tw.addr = 13'((s_reg.ptr + `TBU_WORD_BYTES)
					>> 2);
				s_next.tw.data = s_reg.w1;
				// Hardware advance wins over a software pointer write.
				s_next.ptr = ptr_nxt;
				s_next.wrap = s_next.wrap | wrap_hit;
				if (wm_hit && s_reg.flow[`TBU_FLOW_STOP_BIT] && !mst_wr)
				begin
					s_next.master[`TBU_MASTER_EN_BIT] = 1'b0;
				end
				s_next.halt = wm_hit && s_reg.flow[`TBU_FLOW_HALT_BIT];
				s_next.phase = TBU_IDLE;
			end
			default:
			begin
				s_next.phase = TBU_IDLE;
			end
		endcase
	end

	// Register the state; synchronous reset to idle, tracing off.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_reg <= '0;
			s_reg.phase <= TBU_IDLE;
			s_reg.master <= `TBU_MASTER_RESET;
			s_reg.flow <= `TBU_FLOW_RESET;
		end
		else
		begin
			s_reg <= s_next;
		end
	end

	assign halt_req = s_reg.halt;

	// ==========================================================
	// Checks
	// ==========================================================
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_packet_pair: assert property ((s_reg.phase == TBU_IDLE && ev)
		|=> s_reg.tw.en ##1 s_reg.tw.en ##1
		(!s_reg.tw.en || s_reg.phase == TBU_WORD1))
		else $error("packet is not two SRAM words");
	a_trace_off: assert property ((s_reg.phase == TBU_IDLE &&
		!trace_en) |=> !s_reg.tw.en)
		else $error("trace write while disabled");
	a_ring_wrap: assert property ((s_reg.phase == TBU_WORD1 &&
		wrap_hit) |=> s_reg.wrap && ((s_reg.ptr & bmask) == '0))
		else $error("pointer did not wrap to ring start");
	a_auto_stop: assert property ((s_reg.phase == TBU_WORD1 && wm_hit
		&& s_reg.flow[0] && !mst_wr) |=> !trace_en)
		else $error("threshold did not stop tracing");
	a_halt_pulse: assert property ((s_reg.phase == TBU_WORD1 &&
		wm_hit && s_reg.flow[1]) |=> halt_req ##1 !halt_req)
		else $error("halt request not one pulse");
	a_sw_enable: assert property (mst_wr |=>
		trace_en == $past(regwr.data[31]))
		else $error("enable write not honoured");

	c_packet: cover property (s_reg.phase == TBU_WORD1);
	c_wrap: cover property (s_reg.phase == TBU_WORD1 && wrap_hit);
	c_stop: cover property (s_reg.phase == TBU_WORD1 && wm_hit &&
		s_reg.flow[0]);
	c_contend: cover property (s_reg.tw.en && cpu_req.en);
endmodule

/* rtl/tbu_defs.svh */
// Constants of the program flow trace buffer: register indices, field
// positions, reset values and the SRAM geometry.
// Assumes inclusion by the package and by each design file that needs it.
`ifndef TBU_DEFS_SVH
`define TBU_DEFS_SVH

// ==========================================================
// Register window on the AXI4-Lite bus
// ==========================================================
`define TBU_BASE_ADDR       32'h4100_6000
`define TBU_REG_POSITION    2'h0
`define TBU_REG_MASTER      2'h1
`define TBU_REG_FLOW        2'h2
`define TBU_REG_SRAMBASE    2'h3
`define TBU_RESP_OKAY       2'h0
`define TBU_RESP_SLVERR     2'h2

// ==========================================================
// Field positions and writable masks
// ==========================================================
`define TBU_MASTER_EN_BIT   31
`define TBU_MASTER_RW       32'h8000_001F
`define TBU_POS_WRAP_BIT    2
`define TBU_FLOW_STOP_BIT   0
`define TBU_FLOW_HALT_BIT   1
`define TBU_FLOW_RW         32'h0000_7FFB
`define TBU_MASTER_RESET    32'h0000_0000
`define TBU_FLOW_RESET      32'h0000_0000

// ==========================================================
// Trace SRAM geometry
// ==========================================================
`define TBU_SRAM_AW         15
`define TBU_SRAM_BASE       32'h2000_0000
`define TBU_PKT_BYTES       15'h0008
`define TBU_WORD_BYTES      15'h0004
`define TBU_MASK_MIN        6'h04

`endif

/* rtl/tbu_pkg.sv */
// Types shared by the trace buffer unit modules.
// Assumes tbu_defs.svh is on the include path.
package tbu_pkg;
	`include "tbu_defs.svh"

	// One SRAM access: enable, write, byte lanes, word address, data.
	typedef struct packed {
		logic                      en;
		logic                      we;
		logic [3:0]                be;
		logic [`TBU_SRAM_AW-3:0]   addr;
		logic [31:0]               data;
	} tbu_sram_cmd_t;

	// One cycle of the processor execution trace interface.
	typedef struct packed {
		logic        valid;
		logic        branch;
		logic        exception;
		logic [31:0] src_pc;
		logic [31:0] dst_pc;
	} tbu_exec_t;

	// Register write strobe from the bus slave.
	typedef struct packed {
		logic        valid;
		logic [1:0]  idx;
		logic [31:0] data;
		logic [3:0]  strb;
	} tbu_regwr_t;

	// Readback image of the four registers.
	typedef struct packed {
		logic [31:0] position;
		logic [31:0] master;
		logic [31:0] flow;
		logic [31:0] sram_base;
	} tbu_regs_t;

	// Packet writer phase.
	typedef enum logic [0:0] {
		TBU_IDLE,
		TBU_WORD1
	} tbu_phase_t;
endpackage

/* rtl/tbu_sram_arb.sv */
// SRAM port arbiter between trace writes and processor accesses.
// Assumes a synchronous SRAM that returns read data one cycle after en.
`timescale 1ns/1ps
module tbu_sram_arb (
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	input  wire tbu_pkg::tbu_sram_cmd_t trace_cmd,
	input  wire tbu_pkg::tbu_sram_cmd_t cpu_req,
	output logic                       cpu_ack,
	output logic                       cpu_rvalid,
	output logic [31:0]                cpu_rdata,
	output tbu_pkg::tbu_sram_cmd_t     sram_cmd,
	input  wire logic [31:0]           sram_rdata
);
	import tbu_pkg::*;

	// Whole state of the arbiter.
	typedef struct packed {
		tbu_sram_cmd_t cmd;
		logic          ack;
		logic          rd_pend;
		logic          rd_wait;  // SRAM read issued; data due next edge.
		logic          rvalid;
		logic [31:0]   rdata;
	} tbu_arb_state_t;

	tbu_arb_state_t s_reg;  // Registered state.
	tbu_arb_state_t s_next; // Next state.

	// ==========================================================
	// Grant selection
	// ==========================================================
	// The trace side never waits, so it needs no grant back; the
	// processor sees its acknowledge slip by two cycles for each trace packet ahead of it.
	always_comb
	begin
		s_next = s_reg;
		s_next.cmd = '0;
		s_next.ack = 1'b0;
		s_next.rd_pend = 1'b0;
		// The command leaves this register a cycle before the SRAM sees
		// it, so read data is caught two edges after the grant.
		s_next.rd_wait = s_reg.rd_pend;
		s_next.rvalid = s_reg.rd_wait;
		if (s_reg.rd_wait)
		begin
			s_next.rdata = sram_rdata;
		end
		if (trace_cmd.en)
		begin
			s_next.cmd = trace_cmd;
		end
		else if (cpu_req.en && !s_reg.ack)
		begin
			// The request is still high in the ack cycle; skip it once.
			s_next.cmd = cpu_req;
			s_next.ack = 1'b1;
			s_next.rd_pend = !cpu_req.we;
		end
	end

	// Register the state; synchronous reset.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_reg <= '0;
		end
		else
		begin
			s_reg <= s_next;
		end
	end

	assign sram_cmd = s_reg.cmd;
	assign cpu_ack = s_reg.ack;
	assign cpu_rvalid = s_reg.rvalid;
	assign cpu_rdata = s_reg.rdata;

	// ==========================================================
	// Checks
	// ==========================================================
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_trace_first: assert property (trace_cmd.en |=> sram_cmd.en &&
		sram_cmd.we && !cpu_ack)
		else $error("trace write not granted first");
	a_cpu_served: assert property ((cpu_req.en && !trace_cmd.en &&
		!cpu_ack) |=> cpu_ack ##1 !cpu_ack)
		else $error("processor access not served");
endmodule

/* rtl/tbu_axil_slave.sv */
// AXI4-Lite slave for the four trace buffer registers.
// Assumes the master holds valid and payload until taken.
`timescale 1ns/1ps
`include "tbu_defs.svh"
module tbu_axil_slave (
	input  wire logic               aclk,
	input  wire logic               aresetn,
	input  wire logic [31:0]        awaddr,
	input  wire logic               awvalid,
	output logic                    awready,
	input  wire logic [31:0]        wdata,
	input  wire logic [3:0]         wstrb,
	input  wire logic               wvalid,
	output logic                    wready,
	output logic [1:0]              bresp,
	output logic                    bvalid,
	input  wire logic               bready,
	input  wire logic [31:0]        araddr,
	input  wire logic               arvalid,
	output logic                    arready,
	output logic [31:0]             rdata,
	output logic [1:0]              rresp,
	output logic                    rvalid,
	input  wire logic               rready,
	input  wire tbu_pkg::tbu_regs_t regs,
	output tbu_pkg::tbu_regwr_t     regwr
);
	import tbu_pkg::*;

	// Whole state of the slave.
	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        arready;
		logic        aw_full;
		logic [31:0] awaddr;
		logic        w_full;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [1:0]  rresp;
		logic [31:0] rdata;
		tbu_regwr_t  wr;
	} tbu_axi_state_t;

	tbu_axi_state_t s_reg;  // Registered state.
	tbu_axi_state_t s_next; // Next state.

	// True when the address falls in the sixteen-byte register window.
	function automatic logic tbu_hit(input logic [31:0] a);
		return a[31:4] == 28'(`TBU_BASE_ADDR >> 4);
	endfunction

	// ==========================================================
	// Channel handling
	// ==========================================================
	// Address and data are caught in either order; the write fires once
	// both are held and the response channel is free.
	always_comb
	begin
		s_next = s_reg;
		s_next.wr = '0;
		if (awvalid && s_reg.awready)
		begin
			s_next.aw_full = 1'b1;
			s_next.awaddr = awaddr;
			s_next.awready = 1'b0;
		end
		if (wvalid && s_reg.wready)
		begin
			s_next.w_full = 1'b1;
			s_next.wdata = wdata;
			s_next.wstrb = wstrb;
			s_next.wready = 1'b0;
		end
		if (s_reg.aw_full && s_reg.w_full && !s_reg.bvalid)
		begin
			s_next.wr.valid = tbu_hit(s_reg.awaddr);
			s_next.wr.idx = s_reg.awaddr[3:2];
			s_next.wr.data = s_reg.wdata;
			s_next.wr.strb = s_reg.wstrb;
			s_next.bvalid = 1'b1;
			s_next.bresp = tbu_hit(s_reg.awaddr) ? `TBU_RESP_OKAY
				: `TBU_RESP_SLVERR;
			s_next.aw_full = 1'b0;
			s_next.w_full = 1'b0;
		end
		if (s_reg.bvalid && bready)
		begin
			s_next.bvalid = 1'b0;
			s_next.awready = 1'b1;
			s_next.wready = 1'b1;
		end
		if (arvalid && s_reg.arready)
		begin
			s_next.arready = 1'b0;
			s_next.rvalid = 1'b1;
			s_next.rresp = `TBU_RESP_SLVERR;
			s_next.rdata = '0;
			if (tbu_hit(araddr))
			begin
				s_next.rresp = `TBU_RESP_OKAY;
				case (araddr[3:2])
					`TBU_REG_POSITION: s_next.rdata = regs.position;
					`TBU_REG_MASTER:   s_next.rdata = regs.master;
					`TBU_REG_FLOW:     s_next.rdata = regs.flow;
					default:           s_next.rdata = regs.sram_base;
				endcase
			end
		end
		if (s_reg.rvalid && rready)
		begin
			s_next.rvalid = 1'b0;
			s_next.arready = 1'b1;
		end
	end

	// Register the state; ready signals come up high after reset.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_reg <= '0;
			s_reg.awready <= 1'b1;
			s_reg.wready <= 1'b1;
			s_reg.arready <= 1'b1;
		end
		else
		begin
			s_reg <= s_next;
		end
	end

	assign awready = s_reg.awready;
	assign wready = s_reg.wready;
	assign arready = s_reg.arready;
	assign bvalid = s_reg.bvalid;
	assign bresp = s_reg.bresp;
	assign rvalid = s_reg.rvalid;
	assign rresp = s_reg.rresp;
	assign rdata = s_reg.rdata;
	assign regwr = s_reg.wr;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_write_resp: assert property ((s_reg.aw_full && s_reg.w_full &&
		!bvalid) |=> bvalid && (regwr.valid == (bresp == 2'h0)))
		else $error("write response or strobe wrong");
endmodule

/* tb/tbu_sram_model.sv */
// Behavioural trace SRAM standing beside the trace buffer unit.
// Assumes word addressing and one-cycle read latency on aclk.
`timescale 1ns/1ps
module tbu_sram_model (
	input  wire logic                   aclk,
	input  wire tbu_pkg::tbu_sram_cmd_t cmd,
	output logic [31:0]                 rdata
);
	import tbu_pkg::*;
	// Word store; the bench reads it as a debugger would.
	logic [31:0] mem [0:8191];
	initial rdata = 32'h0000_0000;
	// Cycles without a read invert the read port so stale data never looks fresh.
	always @(posedge aclk)
	begin
		if (cmd.en && cmd.we)
		begin
			for (int i = 0; i < 4; i++)
				if (cmd.be[i]) mem[cmd.addr][8*i+:8] <= cmd.data[8*i+:8];
		end
		rdata <= (cmd.en && !cmd.we) ? mem[cmd.addr] : ~rdata;
	end
endmodule

/* tb/tb_program_flow_trace_buffer.sv */
// Self-checking bench for the trace buffer unit.
// Assumes tbu_pkg and the SRAM model are compiled first.
`timescale 1ns/1ps
module tb_program_flow_trace_buffer;
	import tbu_pkg::*;
	`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
		bad_count++; $display("BAD %s exp %h got %h", nm, e, g); end end
	// ====================
	// Signals
	// ====================
	logic          aclk = 0, aresetn = 0;
	logic [31:0]   awaddr = '0, wdata = '0, araddr = '0;
	logic          awvalid = 0, wvalid = 0, bready = 0;
	logic          arvalid = 0, rready = 0;
	logic [3:0]    wstrb = 4'hF;
	logic          awready, wready, bvalid, arready, rvalid;
	logic [1:0]    bresp, rresp, r;
	logic [31:0]   rdata, cpu_rdata, sram_rdata, d;
	logic          cpu_ack, cpu_rvalid, halt_req;
	tbu_exec_t     exec_trace = '0;
	tbu_sram_cmd_t cpu_req = '0, sram_cmd;
	int            bad_count = 0, n_checks = 0, halts = 0;
	localparam logic [31:0] B = 32'h4100_6000;

	tbu_top tbu_top_inst (.aclk, .aresetn, .awaddr, .awvalid, .awready,
		.wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
		.araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
		.exec_trace, .cpu_req, .cpu_ack, .cpu_rvalid, .cpu_rdata,
		.sram_cmd, .sram_rdata, .halt_req);
	tbu_sram_model tbu_sram_model_inst (.aclk, .cmd(sram_cmd),
		.rdata(sram_rdata));

	always #5 aclk = ~aclk;
	// Halt pulses are counted so a stuck or doubled pulse shows.
	always @(posedge aclk)
		if (halt_req) halts++;

	// ====================
	// Bus and trace tasks
	// ====================
	// Both write channels are offered together and dropped as taken.
	task automatic wr(input logic [31:0] a, input logic [31:0] v);
	begin
		@(posedge aclk);
		awaddr <= B + a;
		wdata <= v;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		do
		begin
			@(posedge aclk);
			if (awready) awvalid <= 0;
			if (wready) wvalid <= 0;
		end while (!bvalid);
		r = bresp;
		bready <= 0;
	end
	endtask
	task automatic rd(input logic [31:0] a);
	begin
		@(posedge aclk);
		araddr <= B + a;
		arvalid <= 1;
		rready <= 1;
		do
		begin
			@(posedge aclk);
			if (arready) arvalid <= 0;
		end while (!rvalid);
		d = rdata;
		r = rresp;
		rready <= 0;
	end
	endtask
	// One flow change, then idle well beyond the minimum spacing.
	task automatic ev(input logic [31:0] s, input logic [31:0] t,
		input logic x);
	begin
		@(posedge aclk);
		exec_trace <= '{1'b1, !x, x, s, t};
		@(posedge aclk);
		exec_trace.valid <= 0;
		repeat (4) @(posedge aclk);
	end
	endtask
	// Processor access held until acknowledged.
	task automatic cpu(input logic w, input logic [12:0] a,
		input logic [31:0] v);
	begin
		@(posedge aclk);
		cpu_req <= '{1'b1, w, 4'hF, a, v};
		do @(posedge aclk); while (!cpu_ack);
		cpu_req.en <= 0;
		if (!w)
		begin
			do @(posedge aclk); while (!cpu_rvalid);
			d = cpu_rdata;
		end
	end
	endtask
	task automatic give_verdict;
	begin
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	end
	endtask

	// ====================
	// Tests
	// ====================
	initial
	begin
		repeat (10) @(posedge aclk);
		aresetn <= 1;
		rd(32'h0000_0000);
		`CHK("position", 32'h0000_0000, d)
		`CHK("read resp", 2'h0, r)
		rd(32'h0000_0004);
		`CHK("control", 32'h0000_0000, d)
		rd(32'h0000_0008);
		`CHK("flow", 32'h0000_0000, d)
		wr(32'h0000_000C, 32'h0000_1234);
		`CHK("ro write resp", 2'h0, r)
		wr(32'h0000_0010, 32'h8000_0000);
		`CHK("unmapped wr resp", 2'h2, r)
		rd(32'h0000_0004);
		`CHK("unmapped wr ignored", 32'h0000_0000, d)
		rd(32'h0000_000C);
		`CHK("sram base", 32'h2000_0000, d)
		rd(32'h0000_0010);
		`CHK("unmapped resp", 2'h2, r)
		$display("register test done");
		wr(32'h0000_0004, 32'h8000_0000);
		ev(32'h0000_0100, 32'h0000_0200, 0);
		`CHK("word0", 32'h0000_0100, tbu_sram_model_inst.mem[0])
		`CHK("word1", 32'h0000_0201, tbu_sram_model_inst.mem[1])
		rd(32'h0000_0000);
		`CHK("pointer", 32'h0000_0008, d)
		fork
			ev(32'h0000_0300, 32'h0000_0400, 1);
			// Start late so the request meets both trace words.
			begin
				@(posedge aclk);
				cpu(1, 13'h0040, 32'h1234_5678);
			end
		join
		`CHK("exc word0", 32'h0000_0301, tbu_sram_model_inst.mem[2])
		`CHK("exc word1", 32'h0000_0400, tbu_sram_model_inst.mem[3])
		cpu(0, 13'h0040, '0);
		`CHK("cpu data", 32'h1234_5678, d)
		rd(32'h0000_0000);
		`CHK("wrap", 32'h0000_0004, d)
		ev(32'h0000_0500, 32'h0000_0600, 0);
		`CHK("overwrite", 32'h0000_0500, tbu_sram_model_inst.mem[0])
		$display("trace test done");
		wr(32'h0000_0004, 32'h0000_0000);
		ev(32'h0000_0700, 32'h0000_0800, 0);
		rd(32'h0000_0000);
		`CHK("disabled", 32'h0000_000C, d)
		$display("disable test done");
		wr(32'h0000_0000, 32'h0000_0000);
		wr(32'h0000_0008, 32'h0000_000B);
		wr(32'h0000_0004, 32'h8000_0001);
		ev(32'h0000_0900, 32'h0000_0A00, 0);
		rd(32'h0000_0004);
		`CHK("auto stop", 32'h0000_0001, d)
		`CHK("halt pulses", 1, halts)
		ev(32'h0000_0B00, 32'h0000_0C00, 0);
		rd(32'h0000_0000);
		`CHK("stopped ptr", 32'h0000_0008, d)
		$display("threshold test done");
		give_verdict;
	end
	// A hang ends the run through the same verdict.
	initial
	begin
		repeat (20000) @(posedge aclk);
		bad_count++;
		give_verdict;
	end
endmodule
